// ### serial_tx_defs.vh
`ifndef SERIAL_TX_DEFS_VH
`define SERIAL_TX_DEFS_VH
// Frame timing in half-bit clock ticks
`define TICKS_PER_BIT 2'd2
`define STOP_TICKS_1_0 3'd2
`define STOP_TICKS_1_5 3'd3
`define STOP_TICKS_2_0 3'd4
// Stop select strap codes
`define STOP_SEL_1_0 2'h0
`define STOP_SEL_1_5 2'h1
`define STOP_SEL_2_0 2'h2
// Data bit counts
`define DATA_BITS_5 4'd5
`define DATA_BITS_8 4'd8
// Reset values
`define SHIFT_RESET 8'h00
`define LINE_IDLE 1'b1
`endif

// ### sync2.v
`timescale 1ns/10ps
module sync2 #(
  parameter WIDTH = 1
) (
  clk,
  rst_n,
  ce,
  resetValue,
  din,
  dout
);
  input wire clk;
  input wire rst_n;
  input wire ce;
  input wire [WIDTH-1:0] resetValue;
  input wire [WIDTH-1:0] din;
  output reg [WIDTH-1:0] dout;

  reg [WIDTH-1:0] stage1_reg;

  // stage1_reg only feeds dout; resetValue is a constant at each instance
  always @(posedge clk) begin
    if (!rst_n) begin
      stage1_reg <= {WIDTH{1'b0}};
      dout <= resetValue;
    end else if (ce) begin
      stage1_reg <= din;
      dout <= stage1_reg;
    end
  end
endmodule // sync2

// ### serial_char_transmitter.v
`timescale 1ns/10ps
module serial_char_transmitter #(
  parameter MATCH_WIDTH = 3
) (
  clk,
  rst_n,
  ce,
  dataIn,
  enableIn,
  fiveBitMode,
  stopSelect,
  hold_off_n,
  addressMatchInputs,
  select_bypass,
  charLoadPulse,
  indicatorQueryPulse,
  selectedIndicatorClear,
  unconditional_indicator_clear_n,
  initPulse,
  serialLogicOut,
  serialDriveOut,
  charSentIndicator,
  gated_indicator_out_n,
  frameInProgress
);
`include "serial_tx_defs.vh"
  input wire clk;
  input wire rst_n;
  input wire ce;
  input wire [7:0] dataIn;
  input wire enableIn;
  input wire fiveBitMode;
  input wire [1:0] stopSelect;
  input wire hold_off_n;
  input wire [MATCH_WIDTH-1:0] addressMatchInputs;
  input wire select_bypass;
  input wire charLoadPulse;
  input wire indicatorQueryPulse;
  input wire selectedIndicatorClear;
  input wire unconditional_indicator_clear_n;
  input wire initPulse;
  output reg serialLogicOut;
  output reg serialDriveOut;
  output reg charSentIndicator;
  output reg gated_indicator_out_n;
  output reg frameInProgress;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_START = 2'b01;
  localparam ST_DATA = 2'b10;
  localparam ST_STOP = 2'b11;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Every control and data pin except rst_n and ce is asynchronous to clk
  wire [20:0] syncIn;
  wire [20:0] syncOut;
  assign syncIn = {dataIn, enableIn, fiveBitMode, stopSelect, hold_off_n,
    select_bypass, charLoadPulse, indicatorQueryPulse, selectedIndicatorClear,
    unconditional_indicator_clear_n, initPulse, (&addressMatchInputs), 1'b0};

  sync2 #(
    .WIDTH(21)
  ) inSync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .resetValue(21'h001108),
    .din(syncIn),
    .dout(syncOut)
  );

  wire [7:0] dataS = syncOut[20:13];
  wire enableS = syncOut[12];
  wire fiveS = syncOut[11];
  wire [1:0] stopSelS = syncOut[10:9];
  wire holdOffS_n = syncOut[8];
  wire bypassS = syncOut[7];
  wire loadS = syncOut[6];
  wire queryS = syncOut[5];
  wire selClearS = syncOut[4];
  wire uncondClearS_n = syncOut[3];
  wire initS = syncOut[2];
  wire matchAllS = syncOut[1];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [2:0] stopTicks;
    input [1:0] sel;
    begin
      case (sel)
        `STOP_SEL_1_0: stopTicks = `STOP_TICKS_1_0;
        `STOP_SEL_1_5: stopTicks = `STOP_TICKS_1_5;
        default: stopTicks = `STOP_TICKS_2_0;
      endcase
    end
  endfunction

  // Bypass strap low with match inputs open acts as always selected
  wire selected = matchAllS | ~bypassS;
  wire loadGo = loadS & selected;
  wire selClearGo = selClearS & selected;
  wire queryGo = queryS & selected;

  // Level load strobe is edge detected so a held level loads only once
  reg loadPrev_reg;
  wire loadEdge = loadGo & ~loadPrev_reg;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [1:0] state_reg, state_next;
  reg [7:0] shift_reg, shift_next;
  reg [3:0] bitCount_reg, bitCount_next;
  reg [2:0] tick_reg, tick_next;
  reg pending_reg, pending_next;
  reg holdLatched_reg, holdLatched_next;
  reg indicatorSet;
  reg line_next;

  always @* begin
    state_next = state_reg;
    shift_next = shift_reg;
    bitCount_next = bitCount_reg;
    tick_next = tick_reg;
    pending_next = pending_reg;
    holdLatched_next = holdLatched_reg;
    indicatorSet = 1'b0;
    line_next = serialLogicOut;
    // Hold-off sampled before stop period defers the next frame
    if (!holdOffS_n && state_reg != ST_STOP) begin
      holdLatched_next = 1'b1;
    end else if (holdOffS_n) begin
      holdLatched_next = 1'b0;
    end
    case (state_reg)
      ST_IDLE: begin
        line_next = `LINE_IDLE;
        if (pending_reg && holdOffS_n && !holdLatched_reg) begin
          state_next = ST_START;
          pending_next = 1'b0;
          tick_next = 3'd1;
          line_next = 1'b0;
        end
      end
      ST_START: begin
        line_next = 1'b0;
        if (tick_reg == 3'd0) begin
          tick_next = 3'd1;
          state_next = ST_DATA;
          bitCount_next = fiveS ? `DATA_BITS_5 : `DATA_BITS_8;
          line_next = shift_reg[0];
          shift_next = {1'b0, shift_reg[7:1]};
        end else begin
          tick_next = tick_reg - 3'd1;
        end
      end
      ST_DATA: begin
        if (tick_reg != 3'd0) begin
          tick_next = tick_reg - 3'd1;
        end else if (bitCount_reg == 4'd1) begin
          state_next = ST_STOP;
          line_next = 1'b1;
          indicatorSet = 1'b1;
          // The idle cycle that follows ends the stop period, so count one less here
          tick_next = stopTicks(stopSelS) - 3'd2;
        end else begin
          bitCount_next = bitCount_reg - 4'd1;
          tick_next = 3'd1;
          line_next = shift_reg[0];
          shift_next = {1'b0, shift_reg[7:1]};
        end
      end
      ST_STOP: begin
        line_next = 1'b1;
        if (tick_reg == 3'd0) begin
          state_next = ST_IDLE;
        end else begin
          tick_next = tick_reg - 3'd1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // A load may land at any time; it overwrites shift_reg at once, even mid-frame
    if (loadEdge) begin
      shift_next = dataS;
      pending_next = enableS;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      shift_reg <= `SHIFT_RESET;
      bitCount_reg <= 4'h0;
      tick_reg <= 3'h0;
      pending_reg <= 1'b0;
      holdLatched_reg <= 1'b0;
      loadPrev_reg <= 1'b0;
      serialLogicOut <= `LINE_IDLE;
      serialDriveOut <= `LINE_IDLE;
      charSentIndicator <= 1'b1;
      gated_indicator_out_n <= 1'b1;
      frameInProgress <= 1'b0;
    end else if (ce) begin
      loadPrev_reg <= loadGo;
      if (initS) begin
        state_reg <= ST_IDLE;
        shift_reg <= `SHIFT_RESET;
        pending_reg <= 1'b0;
        holdLatched_reg <= 1'b0;
        tick_reg <= 3'h0;
        bitCount_reg <= 4'h0;
        serialLogicOut <= `LINE_IDLE;
        serialDriveOut <= `LINE_IDLE;
        frameInProgress <= 1'b0;
      end else begin
        state_reg <= state_next;
        shift_reg <= shift_next;
        bitCount_reg <= bitCount_next;
        tick_reg <= tick_next;
        pending_reg <= pending_next;
        holdLatched_reg <= holdLatched_next;
        serialLogicOut <= line_next;
        serialDriveOut <= line_next;
        frameInProgress <= (state_next == ST_START) || (state_next == ST_DATA);
      end
      // Indicator is active low: low means sent; clears drive it high and win
      if (initS || selClearGo || !uncondClearS_n) begin
        charSentIndicator <= 1'b1;
      end else if (indicatorSet) begin
        charSentIndicator <= 1'b0;
      end
      gated_indicator_out_n <= ~(~charSentIndicator & queryGo);
    end
  end
endmodule // serial_char_transmitter

// ### tx_checker_asserts.sv
`timescale 1ns/10ps
module tx_checker #(
  parameter MATCH_WIDTH = 3
) (
  input wire clk,
  input wire rst_n,
  input wire fiveBitMode,
  input wire [MATCH_WIDTH-1:0] addressMatchInputs,
  input wire select_bypass,
  input wire selectedIndicatorClear,
  input wire unconditional_indicator_clear_n,
  input wire initPulse,
  input wire serialLogicOut,
  input wire charSentIndicator,
  input wire gated_indicator_out_n,
  input wire frameInProgress
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire selected = (&addressMatchInputs) || !select_bypass;
  // No clear or init may steal the end of frame
  wire quiet = unconditional_indicator_clear_n && !selectedIndicatorClear && !initPulse;
  reg [4:0] runCnt = 5'h00;
  always @(posedge clk) begin
    runCnt <= frameInProgress ? runCnt + 5'h01 : 5'h00;
  end
  start_space_a: assert property (
    $rose(frameInProgress) |-> !serialLogicOut ##1 !serialLogicOut) else $error("short start");
  bit_hold_a: assert property (
    $changed(serialLogicOut) && frameInProgress && quiet |=> $stable(serialLogicOut))
    else $error("short bit");
  frame_len_a: assert property (
    $fell(frameInProgress) && quiet |-> runCnt == (fiveBitMode ? 5'h0C : 5'h12))
    else $error("bad frame length");
  sent_fall_a: assert property (
    $fell(frameInProgress) && quiet |-> (!charSentIndicator && !frameInProgress) [*2])
    else $error("stop or indicator wrong");
  query_idle_a: assert property (
    charSentIndicator [*4] |-> gated_indicator_out_n) else $error("stray query");
  free_clear_a: assert property (
    !unconditional_indicator_clear_n [*5] |-> charSentIndicator) else $error("no clear");
  sel_clear_a: assert property (
    (selectedIndicatorClear && selected) [*5] |-> charSentIndicator) else $error("no sel clear");
  init_a: assert property (
    initPulse [*5] |-> charSentIndicator && serialLogicOut && !frameInProgress)
    else $error("init ignored");
endmodule // tx_checker
bind serial_char_transmitter tx_checker #(.MATCH_WIDTH(MATCH_WIDTH)) tx_checker_i (.clk, .rst_n,
  .fiveBitMode, .addressMatchInputs, .select_bypass, .selectedIndicatorClear,
  .unconditional_indicator_clear_n, .initPulse, .serialLogicOut, .charSentIndicator,
  .gated_indicator_out_n, .frameInProgress);

// ### line_monitor.sv
`timescale 1ns/10ps
module line_monitor (
  input wire clk,
  input wire line,
  input wire frame,
  output reg [7:0] rxData,
  output reg rxDone
);
  reg [4:0] cnt = 5'h00;
  initial rxDone = 1'b0;
  // Second clock of each bit is sampled, clear of the edge
  always @(posedge clk) begin
    rxDone <= 1'b0;
    if (frame) begin
      cnt <= cnt + 5'h01;
      if (cnt[0] && cnt > 5'h01) begin
        rxData <= {line, rxData[7:1]};
      end
    end else if (cnt != 5'h00) begin
      rxDone <= 1'b1;
      cnt <= 5'h00;
    end
  end
endmodule // line_monitor

// ### test_serial_char_transmitter.sv
`timescale 1ns/10ps
module test_serial_char_transmitter;
  reg clk, rst_n, enableIn, fiveBitMode, hold_off_n, select_bypass, charLoadPulse, initPulse;
  reg indicatorQueryPulse, selectedIndicatorClear, unconditional_indicator_clear_n;
  reg [7:0] dataIn, d;
  reg [1:0] stopSelect;
  reg [2:0] addressMatchInputs;
  wire serialLogicOut, charSentIndicator, gated_indicator_out_n, frameInProgress, rxDone;
  wire serialDriveOut;
  wire [7:0] rxData;
  integer errors = 0, checks = 0, cyc = 0, nFr = 0, n0, i, k;
  serial_char_transmitter serial_char_transmitter_i (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .dataIn(dataIn), .enableIn(enableIn), .fiveBitMode(fiveBitMode), .stopSelect(stopSelect),
    .hold_off_n(hold_off_n), .addressMatchInputs(addressMatchInputs),
    .select_bypass(select_bypass), .charLoadPulse(charLoadPulse),
    .indicatorQueryPulse(indicatorQueryPulse), .selectedIndicatorClear(selectedIndicatorClear),
    .unconditional_indicator_clear_n(unconditional_indicator_clear_n), .initPulse(initPulse),
    .serialLogicOut(serialLogicOut), .serialDriveOut(serialDriveOut),
    .charSentIndicator(charSentIndicator),
    .gated_indicator_out_n(gated_indicator_out_n), .frameInProgress(frameInProgress));
  line_monitor line_monitor_i (.clk(clk), .line(serialLogicOut), .frame(frameInProgress),
    .rxData(rxData), .rxDone(rxDone));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task print_verdict;
    begin
      if (errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rxDone) nFr <= nFr + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      print_verdict;
    end
  end
  task chk(input [7:0] e, input [7:0] g);
    begin
      checks = checks + 1;
      if (e !== g) begin
        errors = errors + 1;
        $display("[FAIL] %0t exp %h got %h", $time, e, g);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #5;
    end
  endtask
  // Load strobe stays one bit time; a longer level would still load only once
  task send(input [7:0] v, input f);
    begin
      n0 = nFr;
      dataIn = v;
      charLoadPulse = 1'b1;
      tick(2);
      charLoadPulse = 1'b0;
      for (i = 0; i < 80 && nFr == n0; i = i + 1) tick(1);
      chk({7'h00, f}, nFr[7:0] - n0[7:0]);
      if (f) chk(v, fiveBitMode ? {3'h0, rxData[7:3]} : rxData);
      chk(8'h01, {7'h00, serialDriveOut});
    end
  endtask
  initial begin
    i = $urandom(32'hFFF7);
    {rst_n, fiveBitMode, stopSelect, charLoadPulse, initPulse, dataIn} = 14'h0000;
    {indicatorQueryPulse, selectedIndicatorClear, select_bypass, addressMatchInputs} = 6'h00;
    {enableIn, hold_off_n, unconditional_indicator_clear_n} = 3'h7;
    tick(5);
    rst_n = 1'b1;
    tick(2);
    for (k = 0; k < 8; k = k + 1) begin
      fiveBitMode = k[0];
      stopSelect = k[2:1];
      d = $urandom;
      if (fiveBitMode) d = d & 8'h1F;
      unconditional_indicator_clear_n = 1'b0;
      tick(5);
      chk(8'h01, {7'h00, charSentIndicator});
      unconditional_indicator_clear_n = 1'b1;
      send(d, 1'b1);
      chk(8'h00, {7'h00, charSentIndicator});
    end
    fiveBitMode = 1'b0;
    enableIn = 1'b0;
    send(8'hA5, 1'b0);
    enableIn = 1'b1;
    hold_off_n = 1'b0;
    send(8'h3C, 1'b0);
    hold_off_n = 1'b1;
    tick(40);
    chk(8'h3C, rxData);
    select_bypass = 1'b1;
    addressMatchInputs = 3'h3;
    send(8'h5A, 1'b0);
    addressMatchInputs = 3'h7;
    send(8'hC3, 1'b1);
    indicatorQueryPulse = 1'b1;
    tick(4);
    chk(8'h00, {7'h00, gated_indicator_out_n});
    indicatorQueryPulse = 1'b0;
    addressMatchInputs = 3'h6;
    selectedIndicatorClear = 1'b1;
    tick(5);
    chk(8'h00, {7'h00, charSentIndicator});
    addressMatchInputs = 3'h7;
    send(8'h81, 1'b1);
    chk(8'h01, {7'h00, charSentIndicator});
    selectedIndicatorClear = 1'b0;
    dataIn = 8'h00;
    charLoadPulse = 1'b1;
    tick(2);
    charLoadPulse = 1'b0;
    tick(4);
    initPulse = 1'b1;
    tick(5);
    chk(8'h03, {6'h00, serialLogicOut, charSentIndicator});
    initPulse = 1'b0;
    tick(30);
    chk(8'h00, {7'h00, frameInProgress});
    print_verdict;
  end
endmodule // test_serial_char_transmitter
